// ### pkg/fpe_consts.vh
// constants for the flash program, erase and protect controller
`ifndef FPE_CONSTS_VH
`define FPE_CONSTS_VH

// register and array map, word addresses on the bus
`define FPE_CTRL_ADDR 16'hFE08
`define FPE_PROT_ADDR 16'hFF7E
`define FPE_ARRAY_TOP 3'h7
`define FPE_ADDR_W 13

// control register field positions
`define FPE_HIGH_VOLTAGE_ENABLE_BIT 3
`define FPE_MASS_BIT 2
`define FPE_ERASE_BIT 1
`define FPE_PGM_BIT 0
`define FPE_CTRL_W 4

// protect start address assembly
`define FPE_PROT_HI 2'h3
`define FPE_PROT_LO 6'h00
`define FPE_PROT_OPEN 8'hFF

// byte values and geometry
`define FPE_ERASED 8'hFF
`define FPE_PAGE_LSB 6
`define FPE_ROW_LSB 5
`define FPE_PAGE_OFS_ALL 6'h3F
`define FPE_PAGE_OFS_ZERO 6'h00

// bus read source select
`define FPE_SRC_NONE 2'h0
`define FPE_SRC_CTRL 2'h1
`define FPE_SRC_ARRAY 2'h2

// timing, each figure in its own unit
`define FPE_CLK_MHZ 100
`define FPE_US_PER_MS 1000
`define FPE_T_SETUP_US 10
`define FPE_PROGRAM_SETUP_TIME_US 5
`define FPE_T_PAGE_ERASE_MS 1
`define FPE_T_MASS_ERASE_MS 4

`endif

// ### hdl/fpe_array.v
// byte-wide storage array of the flash with protect byte tap
`timescale 1ns/10ps
`default_nettype none

module fpe_array #(
  parameter AW = 13,
  parameter DW = 8
)(
  input wire mclk,
  input wire [AW-1:0] addr,
  input wire we,
  input wire and_mode,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] prot_addr,
  output reg [DW-1:0] rdata,
  output wire [DW-1:0] prot_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer i;

  // factory state is fully erased; reset never touches the array
  initial
  begin
    for (i = 0; i < (1<<AW); i = i + 1)
      mem[i] = {DW{1'b1}};
  end

  // programming only clears bits, erase writes the erased value
  always @(posedge mclk)
  begin
    if (we)
      mem[addr] <= and_mode ? (mem[addr] & wdata) : wdata;
    rdata <= mem[addr];
  end

  // protect byte is always visible to the interlock logic
  assign prot_data = mem[prot_addr];

endmodule // fpe_array

`default_nettype wire

// ### hdl/fpe_flash_ctrl.v
// flash program and erase sequencer with block protection, avalon-mm slave
// Functional notes
// RULE_01: array reads give one for erased bits, zero for programmed bits
// RULE_02: pages hold two rows; erase unit 64 bytes, program unit 32 bytes
// RULE_03: high voltage sets only with a select bit and finished preceding steps
// RULE_04: mass bit chooses whole-array erase over single page erase
// RULE_05: erase and program selects are never both one, nor set together
// RULE_06: erase pages are 64-byte aligned; vector area is a page of its own
// RULE_07: software page erase order and waits
// RULE_08: software prefers the 4 ms page erase above 1000 cycles
// RULE_09: software mass erase order and waits
// RULE_10: mass erase refused unless the protect byte is all ones; checked only as high voltage sets, so a later mass bit erases the array
// RULE_11: one program cycle targets one aligned row; other rows fail
// RULE_12: software programs only bytes that are still erased
// RULE_13: program select latches address and data; program order and waits
// RULE_14: software keeps each byte within the longest program time
// RULE_15: software keeps cumulative high voltage time on a row bounded
// RULE_16: protect byte is read after select and before high voltage
// RULE_17: high voltage refused when the target lies in the protected range
// RULE_18: protection runs from the derived start up to the array top
// RULE_19: non-open protect byte blocks changes to itself and its block; the code checks only the derived range, so FE leaves FF7E and its page open
// RULE_20: test high voltage on the interrupt pin bypasses protection
// RULE_21: protect byte is erased with its page when unprotected
// RULE_22: protect byte lives in the array and survives reset
// RULE_23: start address is ones, protect byte, then six zero bits
// RULE_24: first array write after select latches the target page or row
`timescale 1ns/10ps
`default_nettype none
`include "fpe_consts.vh"

module fpe_flash_ctrl #(
  parameter CNT_W = 20,
  parameter [CNT_W-1:0] PAGE_ERASE_CYC = `FPE_T_PAGE_ERASE_MS * `FPE_US_PER_MS * `FPE_CLK_MHZ,
  parameter [CNT_W-1:0] MASS_ERASE_CYC = `FPE_T_MASS_ERASE_MS * `FPE_US_PER_MS * `FPE_CLK_MHZ
)(
  input wire mclk,
  input wire rst_n,
  input wire [15:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire test_high_voltage,
  output wire high_voltage_enable,
  output wire program_row_fail,
  output wire erase_active
);

  localparam AW = `FPE_ADDR_W;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RD = 2'h1;
  localparam [1:0] S_ERASE = 2'h2;
  localparam [CNT_W-1:0] SETUP_CYC = `FPE_T_SETUP_US * `FPE_CLK_MHZ;
  localparam [CNT_W-1:0] PGS_CYC = `FPE_PROGRAM_SETUP_TIME_US * `FPE_CLK_MHZ;
  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam [15:0] PROT_FULL = `FPE_PROT_ADDR;
  localparam [AW-1:0] PROT_IDX = PROT_FULL[AW-1:0];

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg ack_reg;
  reg [31:0] rdata_reg;
  reg [1:0] src_reg;
  reg high_voltage_enable_reg;
  reg mass_reg;
  reg erase_reg;
  reg pgm_reg;
  reg prot_seen_reg;
  reg tgt_valid_reg;
  reg [AW-1:0] tgt_reg;
  reg row_fail_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [AW-1:0] sweep_reg;
  reg [AW-1:0] sweep_last_reg;
  reg tst_meta_reg;
  reg tst_sync_reg;

  wire [7:0] arr_rdata;
  wire [7:0] prot_byte;
  wire [AW-1:0] arr_addr;
  wire arr_we;
  wire [7:0] arr_wdata;

  // test voltage comparator output crosses in through two flops
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tst_meta_reg <= 1'b0;
      tst_sync_reg <= 1'b0;
    end
    else
    begin
      tst_meta_reg <= test_high_voltage;
      tst_sync_reg <= tst_meta_reg;
    end
  end

  // address decode; the control word sits inside the array window
  wire is_ctrl = (avs_address == `FPE_CTRL_ADDR);
  wire is_prot = (avs_address == `FPE_PROT_ADDR);
  wire in_array = (avs_address[15:AW] == `FPE_ARRAY_TOP) && !is_ctrl;
  wire [AW-1:0] idx = avs_address[AW-1:0];
  wire take = (state_reg == S_IDLE) && !ack_reg && (avs_read || avs_write);
  wire take_wr = take && avs_write && avs_byteenable[0];
  wire take_rd = take && avs_read;

  // protected range from derived start to the top of the array
  wire [15:0] prot_start = {`FPE_PROT_HI, prot_byte, `FPE_PROT_LO}; // see RULE_23
  wire prot_open = (prot_byte == `FPE_PROT_OPEN) || tst_sync_reg; // see RULE_18, see RULE_20
  wire [15:0] tgt_addr = {`FPE_ARRAY_TOP, tgt_reg};
  wire tgt_protected = !prot_open && (tgt_addr >= prot_start); // see RULE_17, see RULE_19

  // conditions that gate the high voltage step
  wire any_sel = erase_reg || pgm_reg;
  wire setup_done = (cnt_reg >= SETUP_CYC);
  wire mass_erase = erase_reg && mass_reg; // see RULE_04
  wire range_ok = mass_erase ? prot_open : !tgt_protected; // see RULE_10
  wire hv_allowed = any_sel && prot_seen_reg && tgt_valid_reg && setup_done && range_ok; // see RULE_03

  // control write fields
  wire w_ctrl = take_wr && is_ctrl;
  wire w_pgm = avs_writedata[`FPE_PGM_BIT];
  wire w_erase = avs_writedata[`FPE_ERASE_BIT];
  wire w_mass = avs_writedata[`FPE_MASS_BIT];
  wire w_high_voltage_enable = avs_writedata[`FPE_HIGH_VOLTAGE_ENABLE_BIT];
  wire w_both = w_pgm && w_erase;

  // next selects: a write asking for both keeps the old pair
  wire erase_new = w_both ? erase_reg : w_erase; // see RULE_05
  wire pgm_new = w_both ? pgm_reg : w_pgm; // see RULE_05
  wire high_voltage_enable_new = w_high_voltage_enable && (high_voltage_enable_reg || hv_allowed); // see RULE_03, see RULE_17
  wire hv_rise = w_ctrl && high_voltage_enable_new && !high_voltage_enable_reg;

  // erase takes effect when select drops under high voltage after the minimum time
  wire [CNT_W-1:0] erase_need = mass_reg ? MASS_ERASE_CYC : PAGE_ERASE_CYC;
  wire erase_commit = w_ctrl && erase_reg && high_voltage_enable_reg && !erase_new && (cnt_reg >= erase_need);

  // first array write after select, before high voltage, latches the target
  wire tgt_latch = take_wr && in_array && any_sel && !high_voltage_enable_reg && !tgt_valid_reg; // see RULE_24

  // byte program: only inside the latched row, after program setup time
  wire same_row = (idx[AW-1:`FPE_ROW_LSB] == tgt_reg[AW-1:`FPE_ROW_LSB]); // see RULE_02
  wire prog_try = take_wr && in_array && pgm_reg && high_voltage_enable_reg && tgt_valid_reg && !row_fail_reg
                  && (cnt_reg >= PGS_CYC); // see RULE_13
  wire prog_we = prog_try && same_row; // see RULE_11
  wire prog_bad = prog_try && !same_row; // see RULE_11

  // sweep bounds of an erase, page aligned or the whole array
  wire [AW-1:0] page_first = {tgt_reg[AW-1:`FPE_PAGE_LSB], `FPE_PAGE_OFS_ZERO}; // see RULE_06
  wire [AW-1:0] page_last = {tgt_reg[AW-1:`FPE_PAGE_LSB], `FPE_PAGE_OFS_ALL}; // see RULE_06

  // array port shared by bus access, byte programming and erase sweep
  assign arr_addr = (state_reg == S_ERASE) ? sweep_reg : idx;
  assign arr_we = (state_reg == S_ERASE) || prog_we;
  assign arr_wdata = (state_reg == S_ERASE) ? `FPE_ERASED : avs_writedata[7:0];

  fpe_array #(
    .AW(AW),
    .DW(8)
  ) u_array (
    .mclk(mclk),
    .addr(arr_addr),
    .we(arr_we),
    .and_mode(state_reg != S_ERASE),
    .wdata(arr_wdata),
    .prot_addr(PROT_IDX),
    .rdata(arr_rdata),
    .prot_data(prot_byte)
  ); // see RULE_22

  // bus state machine: reads take two edges, erases hold the bus for the sweep
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (erase_commit)
          state_next = S_ERASE;
        else if (take_rd)
          state_next = S_RD;
      end
      S_RD:
        state_next = S_IDLE;
      S_ERASE:
      begin
        if (sweep_reg == sweep_last_reg)
          state_next = S_IDLE;
      end
      default:
        state_next = S_IDLE;
    endcase
  end

  // state, answer pulse and read data
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg <= S_IDLE;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      src_reg <= `FPE_SRC_NONE;
    end
    else
    begin
      state_reg <= state_next;
      ack_reg <= 1'b0;
      if (take && !erase_commit && !take_rd)
        ack_reg <= 1'b1;
      if (take_rd)
        src_reg <= is_ctrl ? `FPE_SRC_CTRL : (in_array ? `FPE_SRC_ARRAY : `FPE_SRC_NONE);
      if (state_reg == S_RD)
      begin
        ack_reg <= 1'b1;
        case (src_reg)
          `FPE_SRC_CTRL:
            rdata_reg <= {28'h0000000, high_voltage_enable_reg, mass_reg, erase_reg, pgm_reg};
          `FPE_SRC_ARRAY:
            rdata_reg <= {24'h000000, arr_rdata}; // see RULE_01
          default:
            rdata_reg <= 32'h00000000;
        endcase
      end
      if ((state_reg == S_ERASE) && (sweep_reg == sweep_last_reg))
        ack_reg <= 1'b1;
    end
  end

  // erase sweep address walk
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sweep_reg <= {AW{1'b0}};
      sweep_last_reg <= {AW{1'b0}};
    end
    else if (erase_commit)
    begin
      sweep_reg <= mass_reg ? {AW{1'b0}} : page_first; // see RULE_04, see RULE_21
      sweep_last_reg <= mass_reg ? {AW{1'b1}} : page_last; // see RULE_02
    end
    else if (state_reg == S_ERASE)
      sweep_reg <= sweep_reg + {{(AW-1){1'b0}}, 1'b1};
  end

  // control bits with their interlocks
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      high_voltage_enable_reg <= 1'b0;
      mass_reg <= 1'b0;
      erase_reg <= 1'b0;
      pgm_reg <= 1'b0;
    end
    else if (w_ctrl)
    begin
      high_voltage_enable_reg <= high_voltage_enable_new; // see RULE_03
      mass_reg <= w_mass; // see RULE_04
      erase_reg <= erase_new; // see RULE_05
      pgm_reg <= pgm_new; // see RULE_05
    end
  end

  // sequence tracking: protect read, target latch, row failure
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      prot_seen_reg <= 1'b0;
      tgt_valid_reg <= 1'b0;
      tgt_reg <= {AW{1'b0}};
      row_fail_reg <= 1'b0;
    end
    else if (w_ctrl && !erase_new && !pgm_new)
    begin
      // both selects gone: the next cycle starts from scratch
      prot_seen_reg <= 1'b0;
      tgt_valid_reg <= 1'b0;
      row_fail_reg <= 1'b0;
    end
    else
    begin
      if (take_rd && is_prot && any_sel && !high_voltage_enable_reg)
        prot_seen_reg <= 1'b1; // see RULE_16
      if (tgt_latch)
      begin
        tgt_valid_reg <= 1'b1; // see RULE_24
        tgt_reg <= idx;
      end
      if (prog_bad)
        row_fail_reg <= 1'b1; // see RULE_11
    end
  end

  // elapsed time since target latch, restarted when high voltage comes on
  always @(posedge mclk)
  begin
    if (!rst_n)
      cnt_reg <= {CNT_W{1'b0}};
    else if (tgt_latch || hv_rise)
      cnt_reg <= {CNT_W{1'b0}};
    else if (cnt_reg != CNT_MAX)
      cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // bus answer and status outputs
  assign avs_waitrequest = !ack_reg;
  assign avs_readdata = rdata_reg;
  assign high_voltage_enable = high_voltage_enable_reg;
  assign program_row_fail = row_fail_reg;
  assign erase_active = (state_reg == S_ERASE);

endmodule // fpe_flash_ctrl

`default_nettype wire

// ### test/fpe_flash_ctrl_sva.sv
// port checker for the flash sequencer
`timescale 1ns/10ps
`default_nettype none
module fpe_flash_ctrl_sva (
  input wire mclk,
  input wire rst_n,
  input wire [15:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire test_high_voltage,
  input wire high_voltage_enable,
  input wire program_row_fail,
  input wire erase_active
);
  logic [13:0] run_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // length of the current erase sweep
  always @(posedge mclk)
    run_reg <= erase_active ? run_reg + 14'h1 : 14'h0;
  a_sweep_len: assert property ($fell(erase_active) |-> run_reg == 14'h40 || run_reg == 14'h2000)
    else $error("erase sweep length wrong");
  a_sweep_hv: assert property ($rose(erase_active) |-> $past(high_voltage_enable))
    else $error("erase without high voltage");
  a_sweep_busy: assert property (erase_active |-> avs_waitrequest)
    else $error("bus answered during sweep");
  a_read_two: assert property ($rose(avs_read) && avs_waitrequest |-> ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer timing");
  a_write_one: assert property ($rose(avs_write) && !erase_active && avs_address != 16'hFE08 |=> !avs_waitrequest)
    else $error("write answer timing");
  a_hv_by_write: assert property ($rose(high_voltage_enable) |-> $past(avs_write && avs_writedata[3]))
    else $error("high voltage rose without write");
  a_sel_excl: assert property (avs_read && !avs_waitrequest && avs_address == 16'hFE08 |-> !(avs_readdata[1] && avs_readdata[0]))
    else $error("both selects read back set");
  a_fail_cause: assert property ($rose(program_row_fail) |-> $past(avs_write && high_voltage_enable))
    else $error("row fail without program write");
  a_fail_sticky: assert property ($fell(program_row_fail) |-> $past(avs_write) || !$past(rst_n))
    else $error("row fail dropped alone");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |=> avs_waitrequest && !high_voltage_enable)
    else $error("outputs active in reset");
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  c_sweep: cover property ($rose(erase_active));
  c_fail: cover property ($rose(program_row_fail));
  c_bypass: cover property ($rose(high_voltage_enable) && test_high_voltage);
endmodule // fpe_flash_ctrl_sva
`default_nettype wire

// ### test/flash_program_erase_protect_tb.sv
// self-checking bench for the flash sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fpe_consts.vh"
module flash_program_erase_protect_tb;
  logic mclk = 0;
  logic rst_n = 0;
  logic [15:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0] avs_byteenable = 4'hF;
  logic test_high_voltage = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire high_voltage_enable;
  wire program_row_fail;
  wire erase_active;
  logic [7:0] rd_byte;
  int num_errors = 0;
  int samples_checked = 0;
  int sweep_cycles = 0;
  fpe_flash_ctrl #(.PAGE_ERASE_CYC(20'd50), .MASS_ERASE_CYC(20'd100)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .test_high_voltage(test_high_voltage), .high_voltage_enable(high_voltage_enable),
    .program_row_fail(program_row_fail), .erase_active(erase_active));
  // free running clock
  always #5 mclk = ~mclk;
  // count clock edges spent in erase sweeps
  always @(posedge mclk)
    if (erase_active === 1'b1)
      sweep_cycles <= sweep_cycles + 1;
  task complete_run(input logic hung);
    begin
      if (hung)
        num_errors = num_errors + 1;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    begin
      n = 0;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= ~w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0)
      begin
        n = n + 1;
        if (n > 9000)
          complete_run(1);
        @(posedge mclk);
      end
      rd_byte = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task rdc(input logic [15:0] a, input logic [7:0] e);
    begin
      acc(0, a, 8'h00);
      chk(rd_byte, e);
    end
  endtask
  // select, protect read, target latch, setup wait, high voltage
  task arm(input logic [7:0] sel, input logic [15:0] a);
    begin
      acc(1, `FPE_CTRL_ADDR, sel);
      acc(0, `FPE_PROT_ADDR, 8'h00);
      acc(1, a, 8'hFF);
      wt(1000);
      acc(1, `FPE_CTRL_ADDR, sel | 8'h08);
    end
  endtask
  task prog(input logic [15:0] a, input logic [7:0] d);
    begin
      arm(8'h01, a);
      rdc(`FPE_CTRL_ADDR, 8'h09);
      chk({7'h0, high_voltage_enable}, 8'h01);
      wt(510);
      acc(1, a, d);
      acc(1, `FPE_CTRL_ADDR, 8'h08);
      acc(1, `FPE_CTRL_ADDR, 8'h00);
    end
  endtask
  task t_basic;
    begin
      rdc(`FPE_CTRL_ADDR, 8'h00);
      rdc(16'hE000, 8'hFF);
      acc(1, `FPE_CTRL_ADDR, 8'h03);
      rdc(`FPE_CTRL_ADDR, 8'h00);
      acc(1, `FPE_CTRL_ADDR, 8'h08);
      rdc(`FPE_CTRL_ADDR, 8'h00);
      chk({7'h0, high_voltage_enable}, 8'h00);
      avs_byteenable <= 4'hE;
      acc(1, `FPE_CTRL_ADDR, 8'h04);
      avs_byteenable <= 4'hF;
      rdc(`FPE_CTRL_ADDR, 8'h00);
      acc(1, `FPE_CTRL_ADDR, 8'h04);
      rdc(`FPE_CTRL_ADDR, 8'h04);
      acc(1, `FPE_CTRL_ADDR, 8'h02);
      acc(1, 16'hE000, 8'hFF);
      wt(1000);
      acc(1, `FPE_CTRL_ADDR, 8'h0A);
      rdc(`FPE_CTRL_ADDR, 8'h02);
      acc(1, `FPE_CTRL_ADDR, 8'h00);
    end
  endtask
  task t_program;
    begin
      prog(16'hE021, 8'h55);
      rdc(16'hE021, 8'h55);
      arm(8'h01, 16'hE060);
      wt(510);
      acc(1, 16'hE080, 8'h00);
      rdc(`FPE_CTRL_ADDR, 8'h09);
      chk({7'h0, program_row_fail}, 8'h01);
      acc(1, `FPE_CTRL_ADDR, 8'h00);
      rdc(16'hE080, 8'hFF);
      prog(16'hE040, 8'h0F);
    end
  endtask
  task t_erase;
    begin
      arm(8'h02, 16'hE03F);
      rdc(`FPE_CTRL_ADDR, 8'h0A);
      wt(60);
      acc(1, `FPE_CTRL_ADDR, 8'h08);
      chk(sweep_cycles[7:0], 8'h40);
      acc(1, `FPE_CTRL_ADDR, 8'h00);
      rdc(16'hE021, 8'hFF);
      rdc(16'hE040, 8'h0F);
    end
  endtask
  task t_protect;
    begin
      prog(`FPE_PROT_ADDR, 8'hFE);
      arm(8'h02, 16'hFFC0);
      rdc(`FPE_CTRL_ADDR, 8'h02);
      acc(1, `FPE_CTRL_ADDR, 8'h00);
      arm(8'h02, 16'hFF40);
      rdc(`FPE_CTRL_ADDR, 8'h0A);
      acc(1, `FPE_CTRL_ADDR, 8'h00);
      arm(8'h06, 16'hE000);
      rdc(`FPE_CTRL_ADDR, 8'h06);
      acc(1, `FPE_CTRL_ADDR, 8'h00);
      rst_n <= 1'b0;
      wt(4);
      rst_n <= 1'b1;
      wt(2);
      rdc(`FPE_PROT_ADDR, 8'hFE);
      test_high_voltage <= 1'b1;
      wt(4);
      arm(8'h02, 16'hFFC0);
      rdc(`FPE_CTRL_ADDR, 8'h0A);
      acc(1, `FPE_CTRL_ADDR, 8'h00);
      arm(8'h06, 16'hE000);
      wt(110);
      acc(1, `FPE_CTRL_ADDR, 8'h08);
      chk(sweep_cycles[15:8], 8'h20);
      chk(sweep_cycles[7:0], 8'h40);
      acc(1, `FPE_CTRL_ADDR, 8'h00);
      test_high_voltage <= 1'b0;
      rdc(`FPE_PROT_ADDR, 8'hFF);
      rdc(16'hE040, 8'hFF);
    end
  endtask
  // main sequence
  initial
  begin
    wt(4);
    rst_n <= 1'b1;
    wt(2);
    t_basic;
    t_program;
    t_erase;
    t_protect;
    complete_run(0);
  end
endmodule // flash_program_erase_protect_tb
bind fpe_flash_ctrl fpe_flash_ctrl_sva chk_u (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .test_high_voltage(test_high_voltage),
  .high_voltage_enable(high_voltage_enable), .program_row_fail(program_row_fail), .erase_active(erase_active));
`default_nettype wire
